// File: common/color_lut_consts.svh
// Offsets, field positions and mode codes of the color table access block
`ifndef COLOR_LUT_CONSTS_SVH
`define COLOR_LUT_CONSTS_SVH

// ============================================================
// Register offsets
`define LUT_LOAD_OFS      8'h18
`define LUT_READBACK_OFS  8'h1c

// ============================================================
// Field positions
`define LUT_PTR_HI        31
`define LUT_PTR_LO        24
`define LUT_RED_HI        23
`define LUT_RED_LO        18
`define LUT_GREEN_HI      15
`define LUT_GREEN_LO      10
`define LUT_BLUE_HI       7
`define LUT_BLUE_LO       2

// ============================================================
// Byte lanes
`define LANE_PTR          3
`define LANE_RED          2
`define LANE_GREEN        1
`define LANE_BLUE         0

// ============================================================
// Reset values and answers
`define PTR_RESET         8'h00
`define READ_ZERO         32'h0000_0000
`define PAD2              2'h0
`define PAD8              8'h00

// ============================================================
// Color depth codes
`define BPP_1             5'h01
`define BPP_2             5'h02
`define BPP_4             5'h04
`define BPP_8             5'h08
`define BPP_16            5'h10

`endif

// File: common/color_lut_pkg.sv
// Types shared by the color table access block
package color_lut_pkg;
    typedef logic [5:0] color_t;
    typedef logic [7:0] lut_index_t;
    typedef enum logic [1:0] {
        STRAP_WAIT = 2'b00,
        STRAP_DONE = 2'b01
    } strap_state_t;
endpackage

// File: rtl/color_table.sv
// One 256 entry color table with one write port and two read ports
`timescale 1ns/1ps
module color_table
    import color_lut_pkg::*;
#(
    parameter int DEPTH = 256,
    parameter int WIDTH = 6,
    parameter int AW    = 8
) (
    // Clock
    input  wire logic             clk,
    // Write port
    input  wire logic             wr_en,
    input  wire logic [AW-1:0]    wr_addr,
    input  wire logic [WIDTH-1:0] wr_data,
    // Read ports
    input  wire logic [AW-1:0]    host_addr,
    output logic      [WIDTH-1:0] host_data,
    input  wire logic [AW-1:0]    pix_addr,
    output logic      [WIDTH-1:0] pix_data
);

    logic [WIDTH-1:0] mem [DEPTH];

    // ============================================================
    // Storage
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    // ============================================================
    // Read ports
    always_comb begin
        host_data = mem[host_addr];
        pix_data  = mem[pix_addr];
    end

endmodule

// File: rtl/color_lut_access.sv
// Host load and readback port of the color tables, with the pixel lookup path
//
// Overview of operation
// RL1 - Three separate tables for red, green, blue; 256 entries, 6 bits each.
// RL2 - Load register is write-only; reading it returns zero.
// RL3 - Load bits 31-24 are the write pointer into all three tables.
// RL4 - Load red in 23-18, green in 15-10, blue in 7-2.
// RL5 - Little-endian strap: commit when a write covering the pointer byte completes.
// RL6 - Big-endian strap: commit when a write covering the blue byte completes.
// RL7 - Writing the write pointer also loads the read pointer.
// RL8 - Readback bits 31-24 hold the read pointer; writable, never read back.
// RL9 - Readback read returns red 23-18, green 15-10, blue 7-2 at read pointer.
// RL10 - Readback color fields are read-only; writes leave tables untouched.
// RL11 - Pixels of 1, 2, 4, 8 bpp go through tables; 16 bpp bypasses.
// RL12 - Readback after a committed load shows the new values, never stale data.
`timescale 1ns/1ps
`include "color_lut_consts.svh"
module color_lut_access
    import color_lut_pkg::*;
#(
    parameter int DEPTH = 256,
    parameter int CW    = 6,
    parameter int AW    = 8
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst_n,
    // Strap
    input  wire logic          bus_endian_strap,
    // Host register port
    input  wire logic [7:0]    reg_addr,
    input  wire logic          reg_wr,
    input  wire logic          reg_rd,
    input  wire logic [3:0]    reg_be,
    input  wire logic [31:0]   reg_wdata,
    output logic      [31:0]   reg_rdata,
    // Pixel path in
    input  wire logic          pix_valid,
    input  wire logic [4:0]    bpp_sel,
    input  wire logic [AW-1:0] pix_index,
    input  wire logic [15:0]   pix_direct,
    // Pixel path out
    output logic               pix_out_valid,
    output logic      [CW-1:0] pix_red,
    output logic      [CW-1:0] pix_green,
    output logic      [CW-1:0] pix_blue
);

    // ============================================================
    // Strap capture
    strap_state_t strap_state;
    strap_state_t next_strap_state;
    logic         big_endian;
    logic         next_big_endian;

    always_comb begin
        next_strap_state = strap_state;
        next_big_endian  = big_endian;
        case (strap_state)
            STRAP_WAIT: begin
                next_big_endian  = bus_endian_strap;
                next_strap_state = STRAP_DONE;
            end
            STRAP_DONE: begin
                next_strap_state = STRAP_DONE;
            end
            default: begin
                next_strap_state = STRAP_WAIT;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            strap_state <= STRAP_WAIT;
            big_endian  <= 1'b0;
        end else begin
            strap_state <= next_strap_state;
            big_endian  <= next_big_endian;
        end
    end

    // ============================================================
    // Load staging and commit
    logic           hit_load;
    logic           hit_back;
    lut_index_t     wr_ptr;
    color_t         st_red;
    color_t         st_green;
    color_t         st_blue;
    lut_index_t     next_wr_ptr;
    color_t         next_red;
    color_t         next_green;
    color_t         next_blue;
    logic           commit;
    lut_index_t     rd_ptr;
    lut_index_t     next_rd_ptr;

    always_comb begin
        hit_load    = reg_addr == `LUT_LOAD_OFS;
        hit_back    = reg_addr == `LUT_READBACK_OFS;
        next_wr_ptr = wr_ptr;
        next_red    = st_red;
        next_green  = st_green;
        next_blue   = st_blue;
        next_rd_ptr = rd_ptr;
        commit      = 1'b0;
        if (reg_wr && hit_load) begin
            // RL3 write pointer field
            if (reg_be[`LANE_PTR]) begin
                next_wr_ptr = reg_wdata[`LUT_PTR_HI:`LUT_PTR_LO];
                // RL7 read pointer follows
                next_rd_ptr = reg_wdata[`LUT_PTR_HI:`LUT_PTR_LO];
            end
            // RL4 color fields
            if (reg_be[`LANE_RED]) begin
                next_red = reg_wdata[`LUT_RED_HI:`LUT_RED_LO];
            end
            if (reg_be[`LANE_GREEN]) begin
                next_green = reg_wdata[`LUT_GREEN_HI:`LUT_GREEN_LO];
            end
            if (reg_be[`LANE_BLUE]) begin
                next_blue = reg_wdata[`LUT_BLUE_HI:`LUT_BLUE_LO];
            end
            // RL5 RL6 commit lane by strap
            commit = big_endian ? reg_be[`LANE_BLUE] : reg_be[`LANE_PTR];
        end
        // RL8 RL10 only the pointer byte is writable
        if (reg_wr && hit_back && reg_be[`LANE_PTR]) begin
            next_rd_ptr = reg_wdata[`LUT_PTR_HI:`LUT_PTR_LO];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wr_ptr   <= `PTR_RESET;
            rd_ptr   <= `PTR_RESET;
            st_red   <= '0;
            st_green <= '0;
            st_blue  <= '0;
        end else begin
            wr_ptr   <= next_wr_ptr;
            rd_ptr   <= next_rd_ptr;
            st_red   <= next_red;
            st_green <= next_green;
            st_blue  <= next_blue;
        end
    end

    // ============================================================
    // Tables
    color_t     back_red;
    color_t     back_green;
    color_t     back_blue;
    color_t     lut_red;
    color_t     lut_green;
    color_t     lut_blue;

    // RL1 three independent tables
    color_table #(.DEPTH(DEPTH), .WIDTH(CW), .AW(AW)) u_red (
        .clk       (clk),
        .wr_en     (commit),
        .wr_addr   (next_wr_ptr),
        .wr_data   (next_red),
        .host_addr (rd_ptr),
        .host_data (back_red),
        .pix_addr  (pix_index),
        .pix_data  (lut_red)
    );

    color_table #(.DEPTH(DEPTH), .WIDTH(CW), .AW(AW)) u_green (
        .clk       (clk),
        .wr_en     (commit),
        .wr_addr   (next_wr_ptr),
        .wr_data   (next_green),
        .host_addr (rd_ptr),
        .host_data (back_green),
        .pix_addr  (pix_index),
        .pix_data  (lut_green)
    );

    color_table #(.DEPTH(DEPTH), .WIDTH(CW), .AW(AW)) u_blue (
        .clk       (clk),
        .wr_en     (commit),
        .wr_addr   (next_wr_ptr),
        .wr_data   (next_blue),
        .host_addr (rd_ptr),
        .host_data (back_blue),
        .pix_addr  (pix_index),
        .pix_data  (lut_blue)
    );

    // ============================================================
    // Host read data
    logic [31:0] back_word;
    logic [31:0] next_rdata;

    always_comb begin
        // RL8 pointer reads as zero
        back_word  = {`PAD8, back_red, `PAD2, back_green, `PAD2, back_blue, `PAD2};
        next_rdata = reg_rdata;
        if (reg_rd) begin
            // RL2 load register reads zero
            next_rdata = `READ_ZERO;
            // RL9 RL12 entry at read pointer
            if (hit_back) begin
                next_rdata = back_word;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            reg_rdata <= `READ_ZERO;
        end else begin
            reg_rdata <= next_rdata;
        end
    end

    // ============================================================
    // Pixel path
    logic    bypass;
    logic    next_pvalid;
    color_t  next_pred;
    color_t  next_pgreen;
    color_t  next_pblue;

    always_comb begin
        bypass      = bpp_sel == `BPP_16;
        next_pvalid = pix_valid;
        next_pred   = pix_red;
        next_pgreen = pix_green;
        next_pblue  = pix_blue;
        if (pix_valid) begin
            // RL11 bypass at 16 bpp, lookup otherwise
            if (bypass) begin
                next_pred   = {pix_direct[15:11], pix_direct[15]};
                next_pgreen = pix_direct[10:5];
                next_pblue  = {pix_direct[4:0], pix_direct[4]};
            end else begin
                next_pred   = lut_red;
                next_pgreen = lut_green;
                next_pblue  = lut_blue;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pix_out_valid <= 1'b0;
            pix_red       <= '0;
            pix_green     <= '0;
            pix_blue      <= '0;
        end else begin
            pix_out_valid <= next_pvalid;
            pix_red       <= next_pred;
            pix_green     <= next_pgreen;
            pix_blue      <= next_pblue;
        end
    end

    // ============================================================
    // Assertions
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence load_ptr_write_s;
        reg_wr && hit_load && reg_be[`LANE_PTR];
    endsequence

    sequence back_read_s;
        reg_rd && hit_back;
    endsequence

    load_reads_zero_a: assert property (reg_rd && hit_load |=> reg_rdata == `READ_ZERO) // RL2
        else $error("load register read not zero");

    ptr_field_a: assert property (load_ptr_write_s |=> wr_ptr == $past(reg_wdata[`LUT_PTR_HI:`LUT_PTR_LO])) // RL3
        else $error("write pointer not taken from top byte");

    red_field_a: assert property (reg_wr && hit_load && reg_be[`LANE_RED]
        |=> st_red == $past(reg_wdata[`LUT_RED_HI:`LUT_RED_LO])) // RL4
        else $error("red field misplaced");

    little_commit_a: assert property (((strap_state == STRAP_DONE && !big_endian) and load_ptr_write_s)
        |-> commit) // RL5
        else $error("little endian commit missing");

    big_commit_a: assert property (big_endian && reg_wr && hit_load |-> commit == reg_be[`LANE_BLUE]) // RL6
        else $error("big endian commit without blue byte");

    rd_follow_a: assert property (load_ptr_write_s |=> rd_ptr == wr_ptr) // RL7
        else $error("read pointer did not follow");

    back_ro_a: assert property (reg_wr && hit_back |-> !commit) // RL10
        else $error("readback write touched tables");

    back_fields_a: assert property (back_read_s |=> reg_rdata[31:24] == `PAD8
        && reg_rdata[23:18] == $past(back_red) && reg_rdata[7:2] == $past(back_blue)) // RL9
        else $error("readback fields wrong");

    // Staged green is the committed value once the write edge has passed
    fresh_read_a: assert property (commit && reg_be[`LANE_PTR] ##1 !reg_wr ##1 back_read_s
        |=> reg_rdata[`LUT_GREEN_HI:`LUT_GREEN_LO] == $past(st_green)) // RL12
        else $error("stale readback after load");

    bypass_a: assert property (pix_valid && bypass |=> pix_green == $past(pix_direct[10:5]) && pix_out_valid) // RL11
        else $error("16 bpp did not bypass");

    lookup_a: assert property (pix_valid && !bypass |=> pix_red == $past(lut_red)) // RL11
        else $error("indexed pixel not looked up");

endmodule

// File: tb/host_model.sv
// Host processor model that drives the register port
`timescale 1ns/1ps
module host_model (
    // Clock
    input  wire logic        clk,
    // Register port
    output logic      [7:0]  reg_addr,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic      [3:0]  reg_be,
    output logic      [31:0] reg_wdata,
    input  wire logic [31:0] reg_rdata
);
    initial begin
        reg_addr  = 8'h00;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_be    = 4'h0;
        reg_wdata = 32'h0000_0000;
    end
    // ============================================================
    // Bus cycles, released address and write data lines show inverted values
    task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        @(posedge clk);
        #1;
        reg_addr  = a;
        reg_be    = be;
        reg_wdata = d;
        reg_wr    = 1'b1;
        @(posedge clk);
        #1;
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clk);
        #1;
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge clk);
        #1;
        reg_rd   = 1'b0;
        reg_addr = ~a;
        @(posedge clk);
        #1;
        d = reg_rdata;
    endtask
endmodule

// File: tb/tb_color_lut_access.sv
// Self-checking bench of the color table access block
`timescale 1ns/1ps
`include "color_lut_consts.svh"
module tb_color_lut_access
    import color_lut_pkg::*;
;
    logic        clk;
    logic        rst_n;
    logic        bus_endian_strap;
    logic [7:0]  reg_addr;
    logic        reg_wr;
    logic        reg_rd;
    logic [3:0]  reg_be;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;
    logic        pix_valid;
    logic [4:0]  bpp_sel;
    lut_index_t  pix_index;
    logic [15:0] pix_direct;
    logic        pix_out_valid;
    color_t      pix_red;
    color_t      pix_green;
    color_t      pix_blue;
    int          fail_count;
    int          n_tests;
    logic [31:0] lfsr;
    logic [31:0] stage;
    logic [31:0] v;
    logic [31:0] got;
    lut_index_t  rptr;
    color_t      tab_r [256];
    color_t      tab_g [256];
    color_t      tab_b [256];
    logic [4:0]  codes [6] = '{`BPP_1, `BPP_2, `BPP_4, `BPP_8, `BPP_16, 5'h03};

    color_lut_access dut (
        .clk(clk), .rst_n(rst_n), .bus_endian_strap(bus_endian_strap),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_be(reg_be),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .pix_valid(pix_valid), .bpp_sel(bpp_sel), .pix_index(pix_index),
        .pix_direct(pix_direct), .pix_out_valid(pix_out_valid),
        .pix_red(pix_red), .pix_green(pix_green), .pix_blue(pix_blue)
    );
    host_model host (
        .clk(clk), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_be(reg_be), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata)
    );

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // ============================================================
    // Helpers
    function automatic logic [31:0] rnd();
        lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
        return lfsr;
    endfunction
    function automatic logic [31:0] rb_exp(lut_index_t p);
        return {`PAD8, tab_r[p], `PAD2, tab_g[p], `PAD2, tab_b[p], `PAD2};
    endfunction
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
        n_tests++;
        if (seen !== exp) begin
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
            fail_count++;
        end
    endtask
    task automatic results();
        if (fail_count == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task automatic do_reset(input logic s);
        @(posedge clk);
        #1;
        rst_n = 1'b0;
        bus_endian_strap = s;
        repeat (12) @(posedge clk);
        #1;
        rst_n = 1'b1;
        stage = 32'h0000_0000;
        rptr = 8'h00;
        repeat (2) @(posedge clk);
    endtask
    // Write with lane staging, commit lane chosen by the strap
    task automatic put(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
        host.wr(a, be, d);
        if (a == `LUT_READBACK_OFS) begin
            if (be[3]) rptr = d[31:24];
        end else begin
            for (int k = 0; k < 4; k++) if (be[k]) stage[k*8 +: 8] = d[k*8 +: 8];
            if (be[3]) rptr = stage[31:24];
            if (bus_endian_strap ? be[0] : be[3]) begin
                tab_r[stage[31:24]] = stage[23:18];
                tab_g[stage[31:24]] = stage[15:10];
                tab_b[stage[31:24]] = stage[7:2];
            end
        end
    endtask
    task automatic rb();
        host.rd(`LUT_READBACK_OFS, got);
        chk("readback", rb_exp(rptr), got);
    endtask
    task automatic ops(input int n);
        for (int i = 0; i < n; i++) begin
            v = rnd();
            v[31:27] = 5'h00;
            put(v[0] ? `LUT_READBACK_OFS : `LUT_LOAD_OFS, {v[17:16], v[9:8]}, v);
            rb();
        end
    endtask
    task automatic pix(input logic [4:0] bpp);
        logic [17:0] exp;
        v = rnd();
        @(posedge clk);
        #1;
        pix_valid  = 1'b1;
        bpp_sel    = bpp;
        pix_index  = {5'h00, v[18:16]};
        pix_direct = v[15:0];
        @(posedge clk);
        #1;
        pix_valid = 1'b0;
        if (bpp == `BPP_16) exp = {v[15:11], v[15], v[10:5], v[4:0], v[4]};
        else exp = {tab_r[pix_index], tab_g[pix_index], tab_b[pix_index]};
        chk("pixel valid", 32'h1, {31'h0, pix_out_valid});
        chk("pixel color", {14'h0, exp}, {14'h0, pix_red, pix_green, pix_blue});
        @(posedge clk);
        #1;
        chk("pixel valid drop", 32'h0, {31'h0, pix_out_valid});
        chk("pixel color hold", {14'h0, exp}, {14'h0, pix_red, pix_green, pix_blue});
    endtask

    // ============================================================
    // Main sequence
    initial begin
        lfsr = 32'h255e;
        fail_count = 0;
        n_tests = 0;
        rst_n = 1'b0;
        bus_endian_strap = 1'b0;
        pix_valid = 1'b0;
        bpp_sel = `BPP_8;
        pix_index = 8'h00;
        pix_direct = 16'h0000;
        stage = 32'h0000_0000;
        rptr = 8'h00;
        do_reset(1'b0);
        for (int i = 0; i < 8; i++) begin
            v = rnd();
            put(`LUT_LOAD_OFS, 4'hf, {8'(i), v[23:0]});
            rb();
        end
        ops(40);
        host.rd(`LUT_LOAD_OFS, got);
        chk("load read", `READ_ZERO, got);
        host.rd(8'h20, got);
        chk("unmapped read", `READ_ZERO, got);
        foreach (codes[k]) pix(codes[k]);
        do_reset(1'b1);
        ops(40);
        foreach (codes[k]) pix(codes[k]);
        results();
    end

    initial begin
        #(5000 * 100);
        fail_count++;
        results();
    end
endmodule
